/* design/spnrs_consts.svh */
// Register offsets, reset values, limits and timing counts of the catch/retry sequencer.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef SPNRS_CONSTS_SVH
`define SPNRS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPNRS_OFF_CATCH   8'h00
`define SPNRS_OFF_GAIN    8'h04
`define SPNRS_OFF_OUTFN   8'h08
`define SPNRS_OFF_RETRY   8'h0c
`define SPNRS_OFF_STATUS  8'h10
`define SPNRS_OFF_IRQ_ST  8'h14
`define SPNRS_OFF_IRQ_MK  8'h18
`define SPNRS_OFF_DRIVE   8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPNRS_MASK_POWERON 3
`define SPNRS_MASK_PWRLOSS 2
`define SPNRS_MASK_FLTRST  1
`define SPNRS_MASK_ACCEL   0

// ----------------------------------------------------------------------
// Reset values and setting limits
// ----------------------------------------------------------------------
`define SPNRS_RST_MASK    4'h0
`define SPNRS_RST_CEIL    8'h64
`define SPNRS_MIN_CEIL    8'h50
`define SPNRS_MAX_CEIL    8'hc8
`define SPNRS_RST_KP      14'h0064
`define SPNRS_RST_KI      14'h03e8
`define SPNRS_MAX_GAIN    14'h270f
`define SPNRS_RST_TFN     5'h0c
`define SPNRS_RST_RFN     5'h11
`define SPNRS_MAX_FN      5'h14
`define SPNRS_FN_CATCH    5'h0f
`define SPNRS_RST_RCNT    4'h0
`define SPNRS_MAX_RCNT    4'ha
`define SPNRS_RST_RDLY    10'h00a
`define SPNRS_MAX_RDLY    10'h258

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPNRS_CLK_NS      10
`define SPNRS_TENTH_NS    100000000
`define SPNRS_TENTH_CYC   (`SPNRS_TENTH_NS / `SPNRS_CLK_NS)
`define SPNRS_QUIET_S     30
`define SPNRS_QUIET_TENTH (`SPNRS_QUIET_S * 10)
`define SPNRS_PI_SHIFT    12
`define SPNRS_VSTEP_MAX   16'h0040

`endif

/* design/spnrs_pkg.sv */
// Types of the catch/retry sequencer: sequencing states and the register state record.
// Assumes nothing beyond a SystemVerilog compiler.
package spnrs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_CATCH,
    ST_UV,
    ST_WAIT,
    ST_LOCK,
    ST_HALT
  } spnrs_state_t;

  typedef struct packed {
    spnrs_state_t        state;
    logic [3:0]          mask;
    logic [7:0]          ceil;
    logic [13:0]         kp;
    logic [13:0]         ki;
    logic [4:0]          tfn;
    logic [4:0]          rfn;
    logic [3:0]          rcnt;
    logic [9:0]          rdly;
    logic [3:0]          left;
    logic [15:0]         freq;
    logic [15:0]         volt;
    logic signed [33:0]  integ;
    logic [23:0]         pre;
    logic [9:0]          tenths;
    logic                quiet_on;
    logic                after_rst;
    logic [4:0]          irq_st;
    logic [4:0]          irq_mk;
    logic [31:0]         prdata;
  } spnrs_regs_t;

endpackage

/* design/spnrs_top.sv */
// Spinning-shaft catch and automatic trip retry sequencer with an APB register slave.
// Assumes synchronous inputs on i_clk_sys and a current input in percent of rated current.
// How it works
// - Four mask bits pick power-on, power-loss, fault-reset and acceleration catches.
// - Catch caps current at 80..200 percent of rated, default 100.
// - Catch voltage ramp is PI regulated; gains 0..9999, defaults 100 and 1000.
// - Output function code 15 drives transistor or relay output during catch.
// - Input power loss raises undervoltage trip and holds the output.
// - Power return resumes held frequency and ramps voltage under PI.
// - Current over ceiling halts voltage rise and lowers frequency.
// - Current back under ceiling resumes voltage rise, stops frequency fall.
// - Voltage at nominal ends catch; accelerate on toward commanded frequency.
// - Retry starts after delay; count 0..10 default 0, delay 0..60 s default 1.0.
// - Each automatic retry decrements the remaining-retry counter by one.
// - Trip with no retries left disables retry and stays tripped until a fault reset or an input power loss.
// - Terminal or keypad fault reset reloads remaining retries from setting.
// - Thirty trip-free seconds after a retry reload the remaining retries.
// - No retry after undervoltage or emergency halt.
// - After retry delay, motor restarts through the catch routine.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "spnrs_consts.svh"

module spnrs_top #(
  parameter int unsigned P_TENTH_CYC = `SPNRS_TENTH_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_power_ok,
  input  wire logic        i_trip,
  input  wire logic        i_emergency_halt,
  input  wire logic        i_fault_reset,
  input  wire logic        i_key_reset,
  input  wire logic        i_run_cmd,
  input  wire logic        i_power_on_start,
  input  wire logic [15:0] i_cmd_freq,
  input  wire logic [15:0] i_out_current,
  output logic [15:0]      o_freq,
  output logic [15:0]      o_volt,
  output logic             o_drive_on,
  output logic             o_catch_active,
  output logic             o_transistor_output_pin,
  output logic             o_relay_contact_output,
  output logic             o_undervoltage_trip,
  output logic             o_tripped,
  output logic             o_irq
);

  localparam logic [23:0] TENTH_LAST = 24'(P_TENTH_CYC - 1);

  spnrs_pkg::spnrs_regs_t r_reg;
  spnrs_pkg::spnrs_regs_t r_next;

  logic               wr_acc;
  logic               rd_acc;
  logic               setup;
  logic               mapped;
  logic               tick;
  logic               over;
  logic               fault_rst;
  logic signed [17:0] err;
  logic signed [32:0] pprod;
  logic signed [32:0] iprod;
  logic signed [34:0] pisum;
  logic [15:0]        vstep;
  logic [4:0]         ev;

  // ----------------------------------------------------------------------
  // Bus decode and derived levels
  // ----------------------------------------------------------------------
  // Zero wait state: every access ends in its first access cycle
  assign setup     = i_psel & ~i_penable;
  assign wr_acc    = i_psel & i_penable & i_pwrite;
  assign rd_acc    = i_psel & i_penable & ~i_pwrite;
  assign mapped    = (i_paddr[7:5] == 3'h0) && (i_paddr[1:0] == 2'h0);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_prdata  = r_reg.prdata;
  assign tick      = (r_reg.pre == TENTH_LAST);
  assign over      = i_out_current > {8'h00, r_reg.ceil};
  assign fault_rst = i_fault_reset | i_key_reset;

  // Status outputs decoded from the registered state
  assign o_freq                  = r_reg.freq;
  assign o_volt                  = r_reg.volt;
  assign o_catch_active          = (r_reg.state == spnrs_pkg::ST_CATCH);
  assign o_drive_on              = (r_reg.state == spnrs_pkg::ST_RUN) || o_catch_active;
  assign o_undervoltage_trip     = (r_reg.state == spnrs_pkg::ST_UV);
  assign o_tripped               = (r_reg.state == spnrs_pkg::ST_WAIT) ||
                                   (r_reg.state == spnrs_pkg::ST_LOCK) ||
                                   (r_reg.state == spnrs_pkg::ST_HALT);
  assign o_transistor_output_pin = o_catch_active && (r_reg.tfn == `SPNRS_FN_CATCH);
  assign o_relay_contact_output  = o_catch_active && (r_reg.rfn == `SPNRS_FN_CATCH);
  assign o_irq                   = |(r_reg.irq_st & r_reg.irq_mk);

  // ----------------------------------------------------------------------
  // PI term of the catch voltage ramp
  // ----------------------------------------------------------------------
  // Error is headroom below the ceiling; step is clamped so voltage never stalls at zero
  always_comb begin
    err   = $signed({2'b00, 8'h00, r_reg.ceil}) - $signed({2'b00, i_out_current});
    pprod = $signed({1'b0, r_reg.kp}) * err;
    iprod = $signed({1'b0, r_reg.ki}) * err;
    pisum = 35'(pprod) + 35'(r_reg.integ);
    if (pisum <= 35'sd0) begin
      vstep = 16'h0001;
    end else if ((pisum >>> `SPNRS_PI_SHIFT) >= 35'(`SPNRS_VSTEP_MAX)) begin
      vstep = `SPNRS_VSTEP_MAX;
    end else begin
      vstep = 16'(pisum >>> `SPNRS_PI_SHIFT);
      if (vstep == 16'h0000) begin
        vstep = 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ev     = 5'h00;

    // Tenth-second prescaler shared by retry delay and quiet period
    if (tick) begin
      r_next.pre    = 24'h000000;
      r_next.tenths = (r_reg.tenths == 10'h3ff) ? r_reg.tenths : r_reg.tenths + 10'h001;
    end else begin
      r_next.pre = r_reg.pre + 24'h000001;
    end

    // Sequencer
    unique case (r_reg.state)
      spnrs_pkg::ST_IDLE: begin
        r_next.freq = 16'h0000;
        r_next.volt = 16'h0000;
        if (i_run_cmd && i_power_ok && !i_emergency_halt) begin
          r_next.after_rst = 1'b0;
          if ((i_power_on_start && r_reg.mask[`SPNRS_MASK_POWERON]) ||
              (r_reg.after_rst && r_reg.mask[`SPNRS_MASK_FLTRST]) ||
              r_reg.mask[`SPNRS_MASK_ACCEL]) begin
            r_next.state = spnrs_pkg::ST_CATCH;
            r_next.freq  = i_cmd_freq;
            r_next.integ = 34'sd0;
            ev[2]        = 1'b1;
          end else begin
            r_next.state = spnrs_pkg::ST_RUN;
          end
        end
      end
      spnrs_pkg::ST_RUN,
      spnrs_pkg::ST_CATCH: begin
        if (r_reg.state == spnrs_pkg::ST_RUN) begin
          // Accelerate or decelerate one step toward the command, V/f held at one
          if (r_reg.freq < i_cmd_freq) begin
            r_next.freq = r_reg.freq + 16'h0001;
          end else if (r_reg.freq > i_cmd_freq) begin
            r_next.freq = r_reg.freq - 16'h0001;
          end
          r_next.volt = r_next.freq;
        end else if (over) begin
          // Hold voltage, shed frequency until current falls
          r_next.freq = (r_reg.freq == 16'h0000) ? 16'h0000 : r_reg.freq - 16'h0001;
        end else begin
          // Raise voltage under PI, frequency stays put
          if (!r_reg.integ[33] && r_reg.integ < 34'sh040000000) begin
            r_next.integ = r_reg.integ + 34'(iprod);
          end
          if (vstep >= r_reg.freq - r_reg.volt || r_reg.volt >= r_reg.freq) begin
            r_next.volt  = r_reg.freq;
            r_next.state = spnrs_pkg::ST_RUN;
            ev[3]        = 1'b1;
          end else begin
            r_next.volt = r_reg.volt + vstep;
          end
        end
        // Quiet period after a retry reloads the budget
        if (r_reg.quiet_on && r_reg.tenths >= 10'(`SPNRS_QUIET_TENTH)) begin
          r_next.left     = r_reg.rcnt;
          r_next.quiet_on = 1'b0;
        end
        if (!i_run_cmd) begin
          r_next.state = spnrs_pkg::ST_IDLE;
          r_next.freq  = 16'h0000;
          r_next.volt  = 16'h0000;
        end
        if (i_trip) begin
          r_next.volt     = 16'h0000;
          r_next.pre      = 24'h000000;
          r_next.tenths   = 10'h000;
          r_next.quiet_on = 1'b0;
          ev[0]           = 1'b1;
          if (r_reg.left == 4'h0) begin
            r_next.state = spnrs_pkg::ST_LOCK;
            ev[4]        = 1'b1;
          end else begin
            r_next.state = spnrs_pkg::ST_WAIT;
          end
        end
      end
      spnrs_pkg::ST_WAIT: begin
        if (r_reg.tenths >= r_reg.rdly) begin
          r_next.state    = spnrs_pkg::ST_CATCH;
          r_next.left     = r_reg.left - 4'h1;
          r_next.volt     = 16'h0000;
          r_next.integ    = 34'sd0;
          r_next.quiet_on = 1'b1;
          r_next.pre      = 24'h000000;
          r_next.tenths   = 10'h000;
          ev[2]           = 1'b1;
        end
      end
      spnrs_pkg::ST_UV: begin
        // Frequency is held so the catch can start from it
        if (i_power_ok) begin
          if (i_run_cmd && r_reg.mask[`SPNRS_MASK_PWRLOSS]) begin
            r_next.state = spnrs_pkg::ST_CATCH;
            r_next.integ = 34'sd0;
            ev[2]        = 1'b1;
          end else begin
            r_next.state = spnrs_pkg::ST_IDLE;
          end
        end
      end
      spnrs_pkg::ST_LOCK,
      spnrs_pkg::ST_HALT: begin
        r_next.volt = 16'h0000;
      end
      default: begin
        r_next.state = spnrs_pkg::ST_IDLE;
      end
    endcase

    // Power loss outranks trips; never feeds the retry path
    if (!i_power_ok && r_reg.state != spnrs_pkg::ST_UV && r_reg.state != spnrs_pkg::ST_HALT) begin
      r_next.state    = spnrs_pkg::ST_UV;
      r_next.volt     = 16'h0000;
      r_next.quiet_on = 1'b0;
      ev[1]           = 1'b1;
    end
    // Emergency halt wins over power loss and trips and blocks retry; a fault reset while tripped still wins
    if (i_emergency_halt && r_reg.state != spnrs_pkg::ST_HALT) begin
      r_next.state = spnrs_pkg::ST_HALT;
      r_next.volt  = 16'h0000;
      ev[0]        = 1'b1;
    end
    // Fault reset from terminal or keypad
    if (fault_rst) begin
      r_next.left = r_reg.rcnt;
      if (o_tripped) begin
        r_next.state     = spnrs_pkg::ST_IDLE;
        r_next.after_rst = 1'b1;
      end
    end

    // Register writes, clamped to the legal setting ranges
    if (wr_acc) begin
      unique case (i_paddr)
        `SPNRS_OFF_CATCH: begin
          r_next.mask = i_pwdata[3:0];
          r_next.ceil = (i_pwdata[15:8] < `SPNRS_MIN_CEIL) ? `SPNRS_MIN_CEIL :
                        (i_pwdata[15:8] > `SPNRS_MAX_CEIL) ? `SPNRS_MAX_CEIL : i_pwdata[15:8];
        end
        `SPNRS_OFF_GAIN: begin
          r_next.kp = (i_pwdata[13:0] > `SPNRS_MAX_GAIN) ? `SPNRS_MAX_GAIN : i_pwdata[13:0];
          r_next.ki = (i_pwdata[29:16] > `SPNRS_MAX_GAIN) ? `SPNRS_MAX_GAIN : i_pwdata[29:16];
        end
        `SPNRS_OFF_OUTFN: begin
          r_next.tfn = (i_pwdata[4:0] > `SPNRS_MAX_FN) ? `SPNRS_MAX_FN : i_pwdata[4:0];
          r_next.rfn = (i_pwdata[12:8] > `SPNRS_MAX_FN) ? `SPNRS_MAX_FN : i_pwdata[12:8];
        end
        `SPNRS_OFF_RETRY: begin
          r_next.rcnt = (i_pwdata[3:0] > `SPNRS_MAX_RCNT) ? `SPNRS_MAX_RCNT : i_pwdata[3:0];
          r_next.rdly = (i_pwdata[25:16] > `SPNRS_MAX_RDLY) ? `SPNRS_MAX_RDLY : i_pwdata[25:16];
        end
        `SPNRS_OFF_IRQ_MK: begin
          r_next.irq_mk = i_pwdata[4:0];
        end
        default: begin
        end
      endcase
    end

    // Sticky events; a read clears, a same-cycle event still lands
    if (rd_acc && i_paddr == `SPNRS_OFF_IRQ_ST) begin
      r_next.irq_st = ev;
    end else begin
      r_next.irq_st = r_reg.irq_st | ev;
    end

    // Read data captured at setup, held through access
    if (setup) begin
      unique case (i_paddr)
        `SPNRS_OFF_CATCH:  r_next.prdata = {16'h0000, r_reg.ceil, 4'h0, r_reg.mask};
        `SPNRS_OFF_GAIN:   r_next.prdata = {2'h0, r_reg.ki, 2'h0, r_reg.kp};
        `SPNRS_OFF_OUTFN:  r_next.prdata = {19'h00000, r_reg.rfn, 3'h0, r_reg.tfn};
        `SPNRS_OFF_RETRY:  r_next.prdata = {6'h00, r_reg.rdly, 12'h000, r_reg.rcnt};
        `SPNRS_OFF_STATUS: r_next.prdata = {20'h00000, r_reg.left, 1'b0, o_undervoltage_trip,
                                            o_tripped, o_catch_active, 1'b0, r_reg.state};
        `SPNRS_OFF_IRQ_ST: r_next.prdata = {27'h0000000, r_reg.irq_st};
        `SPNRS_OFF_IRQ_MK: r_next.prdata = {27'h0000000, r_reg.irq_mk};
        `SPNRS_OFF_DRIVE:  r_next.prdata = {r_reg.volt, r_reg.freq};
        default:           r_next.prdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Clock enable low freezes every field, including the prescaler
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_reg          <= '0;
      r_reg.state    <= spnrs_pkg::ST_IDLE;
      r_reg.mask     <= `SPNRS_RST_MASK;
      r_reg.ceil     <= `SPNRS_RST_CEIL;
      r_reg.kp       <= `SPNRS_RST_KP;
      r_reg.ki       <= `SPNRS_RST_KI;
      r_reg.tfn      <= `SPNRS_RST_TFN;
      r_reg.rfn      <= `SPNRS_RST_RFN;
      r_reg.rcnt     <= `SPNRS_RST_RCNT;
      r_reg.rdly     <= `SPNRS_RST_RDLY;
      r_reg.left     <= `SPNRS_RST_RCNT;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

endmodule

/* verification/spnrs_properties.sv */
// Port checks of the catch/retry sequencer, bound into its top.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module spnrs_properties (
  input wire logic        i_clk_sys,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic        i_power_ok,
  input wire logic        i_trip,
  input wire logic        i_emergency_halt,
  input wire logic        i_fault_reset,
  input wire logic        i_key_reset,
  input wire logic        i_run_cmd,
  input wire logic [15:0] i_cmd_freq,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] o_freq,
  input wire logic [15:0] o_volt,
  input wire logic        o_drive_on,
  input wire logic        o_catch_active,
  input wire logic        o_transistor_output_pin,
  input wire logic        o_relay_contact_output,
  input wire logic        o_undervoltage_trip,
  input wire logic        o_tripped
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Quiet inputs: only the event under test steers state
  wire base = i_ce && !i_emergency_halt && i_run_cmd && !i_fault_reset && !i_key_reset;
  wire calm = base && i_power_ok && !i_trip;
  // Power return straight into a catch, the trigger of the held-frequency check
  sequence s_uv_return;
    o_undervoltage_trip ##1 o_catch_active;
  endsequence
  a_pin_needs_catch: assert property (
    (o_transistor_output_pin || o_relay_contact_output) |-> o_catch_active)
    else $error("function pin high outside catch");
  a_over_ceil_slows: assert property (
    calm && o_catch_active && i_out_current > 16'h00c8 && o_freq != 16'h0000
    |=> o_freq == $past(o_freq) - 16'h0001 && $stable(o_volt)) else $error("no slowdown");
  a_under_ceil_ramps: assert property (
    calm && o_catch_active && i_out_current < 16'h0050 && o_volt < o_freq
    |=> $stable(o_freq) && o_volt > $past(o_volt) && o_volt <= $past(o_volt) + 16'h0040)
    else $error("voltage ramp not resumed");
  a_loss_holds: assert property (
    base && !i_power_ok && !i_trip && o_drive_on
    |=> o_undervoltage_trip && !o_drive_on && o_volt == 16'h0000) else $error("no undervoltage");
  a_resume_held: assert property (s_uv_return |-> $stable(o_freq))
    else $error("held frequency lost");
  a_run_tracks: assert property (
    calm && o_drive_on && !o_catch_active && o_freq < i_cmd_freq
    |=> o_freq == $past(o_freq) + 16'h0001) else $error("no acceleration");
  a_trip_stops: assert property (
    base && i_power_ok && i_trip && o_drive_on |=> o_tripped && !o_drive_on)
    else $error("trip ignored");
  a_retry_via_catch: assert property ($fell(o_tripped) && o_drive_on |-> o_catch_active)
    else $error("retry without catch");
  a_halt_blocks: assert property (
    i_ce && i_emergency_halt && !i_fault_reset && !i_key_reset |-> ##1 !o_drive_on)
    else $error("drive during halt");
  a_reset_clears: assert property (
    i_ce && (i_fault_reset || i_key_reset) && !i_emergency_halt && o_tripped |=> !o_tripped)
    else $error("fault reset ignored");
endmodule
bind spnrs_top spnrs_properties i_chk (.*);

/* verification/spnrs_plant.sv */
// Behavioural motor and power stage facing the sequencer.
// Assumes drive outputs registered on the same system clock.
`timescale 1ns/1ps
module spnrs_plant (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic [15:0] i_freq,
  input  wire logic [15:0] i_volt,
  input  wire logic        i_drive_on,
  input  wire logic        i_surge,
  output logic [15:0]      o_current
);
  logic [15:0] speed_reg;
  // Shaft follows the drive, coasts down slowly when released
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n)
      speed_reg <= 16'h0000;
    else if (i_drive_on)
      speed_reg <= i_freq;
    else if (speed_reg != 16'h0000)
      speed_reg <= speed_reg - 16'h0001;
  end
  // Voltage ahead of the shaft costs current; surge stands for a jammed load
  assign o_current = i_surge ? 16'h00fa
                   : 16'h0028 + ((i_volt > speed_reg) ? i_volt - speed_reg : 16'h0000);
endmodule

/* verification/tb_spinning_restart_sequencer.sv */
// Self-checking bench of the catch/retry sequencer with a motor model.
// Assumes the bound checker and the plant model.
`timescale 1ns/1ps
`include "spnrs_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_spinning_restart_sequencer;
  localparam int TENTH = 8;
  logic        clk, rst_n, ce, psel, pen, pwrite, pready, pslverr, serr, pok, trip;
  logic        estop, frst, krst, run, pos, surge, drv, cat, tpin, rpin, uv, trp, irq;
  logic [3:0]  m;
  logic [7:0]  paddr;
  logic [7:0]  atab [3];
  logic [9:0]  dly;
  logic [15:0] cmd, cur, freq, volt, f;
  logic [31:0] pwdata, prdata, q, d, seed;
  int          err_total, n_checks, cyc, k, n;

  spnrs_top #(.P_TENTH_CYC(TENTH)) i_dut (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_power_ok(pok), .i_trip(trip),
    .i_emergency_halt(estop), .i_fault_reset(frst), .i_key_reset(krst), .i_run_cmd(run),
    .i_power_on_start(pos), .i_cmd_freq(cmd), .i_out_current(cur), .o_freq(freq),
    .o_volt(volt), .o_drive_on(drv), .o_catch_active(cat), .o_transistor_output_pin(tpin),
    .o_relay_contact_output(rpin), .o_undervoltage_trip(uv), .o_tripped(trp), .o_irq(irq));
  spnrs_plant i_plant (.i_clk_sys(clk), .i_arst_n(rst_n), .i_freq(freq), .i_volt(volt),
    .i_drive_on(drv), .i_surge(surge), .o_current(cur));

  // 100 MHz system clock
  always #5 clk = ~clk;
  // Hang guard, far above the planned run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Bus, timing and expectation helpers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= dat;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Lets outputs settle before they are looked at
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  // Waits up to 3000 cycles while the catch flag stays at v
  task automatic wcat(input logic v);
    for (n = 0; n < 3000 && cat === v; n++) @(negedge clk);
  endtask
  function automatic logic [31:0] exp_reg(input logic [7:0] a, input logic [31:0] v);
    logic [7:0]  c;
    logic [13:0] p, i;
    c = (v[15:8] < `SPNRS_MIN_CEIL) ? `SPNRS_MIN_CEIL : v[15:8];
    c = (c > `SPNRS_MAX_CEIL) ? `SPNRS_MAX_CEIL : c;
    p = (v[13:0] > `SPNRS_MAX_GAIN) ? `SPNRS_MAX_GAIN : v[13:0];
    i = (v[29:16] > `SPNRS_MAX_GAIN) ? `SPNRS_MAX_GAIN : v[29:16];
    if (a == `SPNRS_OFF_CATCH)
      return {16'h0000, c, 4'h0, v[3:0]};
    if (a == `SPNRS_OFF_GAIN)
      return {2'b00, i, 2'b00, p};
    return {6'h00, ((v[25:16] > `SPNRS_MAX_RDLY) ? `SPNRS_MAX_RDLY : v[25:16]), 12'h000,
            ((v[3:0] > `SPNRS_MAX_RCNT) ? `SPNRS_MAX_RCNT : v[3:0])};
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {clk, rst_n, psel, pen, pwrite, trip, estop, frst, krst, run, pos, surge} = '0;
    {ce, pok, paddr, pwdata, cmd} = {2'b11, 56'h0};
    seed = 32'ha3764243;
    atab = '{`SPNRS_OFF_CATCH, `SPNRS_OFF_GAIN, `SPNRS_OFF_RETRY};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SPNRS_OFF_CATCH, 32'h0);
    `CHK(q, {16'h0000, `SPNRS_RST_CEIL, 4'h0, `SPNRS_RST_MASK})
    apb(1'b0, `SPNRS_OFF_GAIN, 32'h0);
    `CHK(q, {2'b00, `SPNRS_RST_KI, 2'b00, `SPNRS_RST_KP})
    apb(1'b0, `SPNRS_OFF_OUTFN, 32'h0);
    `CHK(q, {19'h0, `SPNRS_RST_RFN, 3'h0, `SPNRS_RST_TFN})
    apb(1'b0, `SPNRS_OFF_RETRY, 32'h0);
    `CHK(q, {6'h00, `SPNRS_RST_RDLY, 12'h000, `SPNRS_RST_RCNT})
    apb(1'b0, 8'h20, 32'h0);
    `CHK({serr, q}, {1'b1, 32'h0})
    for (k = 0; k < 9; k++) begin
      d = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h0 : $random(seed);
      apb(1'b1, atab[k % 3], d);
      apb(1'b0, atab[k % 3], 32'h0);
      `CHK(q, exp_reg(atab[k % 3], d))
    end
    $display("register test done");
    for (k = 0; k < 16; k++) begin
      m = 4'(k);
      apb(1'b1, `SPNRS_OFF_CATCH, {16'h0000, 8'h64, 4'h0, m});
      pos <= 1'($random(seed));
      run <= 1'b1;
      step(1);
      `CHK({cat, drv}, {(pos & m[3]) | m[0], 1'b1})
      @(posedge clk) run <= 1'b0;
      step(2);
    end
    @(posedge clk) estop <= 1'b1;
    @(posedge clk) {estop, frst} <= 2'b01;
    @(posedge clk) frst <= 1'b0;
    apb(1'b1, `SPNRS_OFF_CATCH, 32'h00006402);
    run <= 1'b1;
    step(1);
    `CHK(cat, 1'b1)
    @(posedge clk) run <= 1'b0;
    $display("catch select test done");
    apb(1'b1, `SPNRS_OFF_OUTFN, 32'h00000f0f);
    apb(1'b1, `SPNRS_OFF_CATCH, 32'h00006401);
    cmd <= 16'h0100;
    run <= 1'b1;
    step(2);
    `CHK({tpin, rpin}, 2'b11)
    f = freq;
    @(posedge clk) surge <= 1'b1;
    step(10);
    `CHK(freq < f, 1'b1)
    @(posedge clk) surge <= 1'b0;
    wcat(1'b1);
    `CHK({cat, drv, tpin, rpin}, 4'b0100)
    for (n = 0; n < 3000 && freq !== cmd; n++) @(negedge clk);
    `CHK(freq, cmd)
    apb(1'b1, `SPNRS_OFF_CATCH, 32'h00006404);
    pok <= 1'b0;
    step(2);
    `CHK({uv, drv, volt, freq}, {2'b10, 16'h0000, 16'h0100})
    @(posedge clk) pok <= 1'b1;
    step(1);
    `CHK({cat, trp, freq}, {2'b10, 16'h0100})
    wcat(1'b1);
    $display("catch dynamics test done");
    dly = 10'(1 + ($random(seed) & 3));
    apb(1'b1, `SPNRS_OFF_RETRY, {6'h00, dly, 16'h0002});
    apb(1'b1, `SPNRS_OFF_IRQ_MK, 32'h0000001f);
    apb(1'b1, `SPNRS_OFF_CATCH, 32'h00006400);
    krst <= 1'b1;
    @(posedge clk) krst <= 1'b0;
    apb(1'b0, `SPNRS_OFF_STATUS, 32'h0);
    `CHK(q[11:8], 4'h2)
    for (k = 0; k < 3; k++) begin
      @(posedge clk) trip <= 1'b1;
      @(posedge clk) trip <= 1'b0;
      wcat(1'b0);
      if (k < 2) begin
        `CHK(n >= dly * TENTH + 1 && n <= dly * TENTH + 3, 1'b1)
        apb(1'b0, `SPNRS_OFF_STATUS, 32'h0);
        `CHK(q[11:8], 4'(1 - k))
        wcat(1'b1);
      end else begin
        `CHK({cat, drv, trp, irq}, 4'b0011)
        apb(1'b0, `SPNRS_OFF_IRQ_ST, 32'h0);
        `CHK(q[4], 1'b1)
        apb(1'b0, `SPNRS_OFF_IRQ_ST, 32'h0);
        step(1);
        `CHK({q[4], irq}, 2'b00)
      end
    end
    @(posedge clk) frst <= 1'b1;
    @(posedge clk) frst <= 1'b0;
    apb(1'b0, `SPNRS_OFF_STATUS, 32'h0);
    `CHK({trp, q[11:8]}, 5'h02)
    @(posedge clk) trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    wcat(1'b0);
    repeat (300 * TENTH - 40) @(posedge clk);
    apb(1'b0, `SPNRS_OFF_STATUS, 32'h0);
    `CHK(q[11:8], 4'h1)
    repeat (80) @(posedge clk);
    apb(1'b0, `SPNRS_OFF_STATUS, 32'h0);
    `CHK(q[11:8], 4'h2)
    $display("retry test done");
    apb(1'b1, `SPNRS_OFF_IRQ_MK, 32'h0);
    estop <= 1'b1;
    trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    step(200);
    `CHK({drv, cat, trp, irq}, 4'b0010)
    apb(1'b0, `SPNRS_OFF_IRQ_ST, 32'h0);
    `CHK(q[0], 1'b1)
    estop <= 1'b0;
    run <= 1'b0;
    $display("halt test done");
    summarize();
  end
endmodule
